// file: design/hpt_cfg_if.sv
// interface: decoded configuration carried from the register bank to the path decider
`timescale 1ns/100ps
interface hpt_cfg_if;
  logic [1:0]  path_sel;
  logic [12:0] thr_mv;
  logic [12:0] rechg_mv;
  logic        thr_valid;
  modport bank    (output path_sel, output thr_mv, output rechg_mv, output thr_valid);
  modport decider (input path_sel, input thr_mv, input rechg_mv, input thr_valid);
endinterface

// file: design/hpt_path_decider.sv
// module: battery-system switch mode decision with recharge hysteresis
`timescale 1ns/100ps
module hpt_path_decider (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  hpt_cfg_if.decider       cfg,
  input  wire logic        charger_input_i,
  input  wire logic        harvest_interaction_enable_i,
  input  wire logic [12:0] battery_mv_i,
  output logic             diode_mode_o,
  output logic             charger_owns_o
);

  typedef struct packed {
    logic diode;
    logic own;
  } hpt_dec_state_t;

  hpt_dec_state_t st;
  hpt_dec_state_t next_st;
  logic [12:0]    low_mv;

  always_comb begin
    next_st = st;
    low_mv  = (cfg.thr_mv > cfg.rechg_mv) ? 13'(cfg.thr_mv - cfg.rechg_mv) : 13'h0000;
    next_st.own = 1'b0;
    if (charger_input_i) begin
      next_st.own   = 1'b1;
      next_st.diode = 1'b0;
    end else if (!harvest_interaction_enable_i) begin
      next_st.diode = 1'b0;
    end else begin
      case (cfg.path_sel)
        2'b00: begin
          next_st.diode = 1'b0;
        end
        2'b01: begin
          if (!cfg.thr_valid) begin
            next_st.diode = 1'b0;
          end else if (!st.diode) begin
            next_st.diode = (battery_mv_i > cfg.thr_mv);
          end else begin
            next_st.diode = !(battery_mv_i < low_mv);
          end
        end
        2'b10: begin
          next_st.diode = 1'b1;
        end
        // reserved code keeps the safe direct path
        default: begin
          next_st.diode = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign diode_mode_o   = st.diode;
  assign charger_owns_o = st.own;

endmodule

// file: design/hpt_pkg.sv
// package: register offsets, field layouts and decode constants for harvester path control
package hpt_pkg;

  localparam logic [7:0] PATH_CONFIG_ADDR   = 8'h18;
  localparam logic [7:0] THERMAL_CFG_ADDR   = 8'h17;
  localparam logic [7:0] PATH_CONFIG_RESET  = 8'h00;
  localparam logic [7:0] THERMAL_CFG_RESET  = 8'h00;

  localparam int PATH_SEL_MSB   = 7;
  localparam int PATH_SEL_LSB   = 6;
  localparam int RECHG_MSB      = 5;
  localparam int RECHG_LSB      = 4;
  localparam int REG_THR_MSB    = 3;
  localparam int REG_THR_LSB    = 0;
  localparam int THERM_SEL_MSB  = 7;
  localparam int THERM_SEL_LSB  = 6;
  localparam int THERM_LOW_MSB  = 4;

  // voltages in millivolts, 13 bits hold up to 8191 mV
  localparam logic [12:0] REG_THR_BASE_MV = 13'h0FD2;
  localparam logic [12:0] REG_THR_STEP_MV = 13'h0032;
  localparam logic [12:0] RECHG_BASE_MV   = 13'h0046;
  localparam logic [12:0] RECHG_STEP_MV   = 13'h0032;
  localparam logic [3:0]  REG_THR_MAX     = 4'hB;

  typedef enum logic [1:0] {
    HPT_PATH_DIRECT = 2'b00,
    HPT_PATH_AUTO   = 2'b01,
    HPT_PATH_DIODE  = 2'b10,
    HPT_PATH_RSVD   = 2'b11
  } hpt_path_t;

  typedef enum logic [1:0] {
    HPT_THERM_OFF   = 2'b00,
    HPT_THERM_CR    = 2'b01,
    HPT_THERM_RW    = 2'b10,
    HPT_THERM_CRW   = 2'b11
  } hpt_therm_t;

  // temperature zone codes seen on the zone input
  typedef enum logic [1:0] {
    HPT_ZONE_COOL = 2'b00,
    HPT_ZONE_ROOM = 2'b01,
    HPT_ZONE_WARM = 2'b10,
    HPT_ZONE_OUT  = 2'b11
  } hpt_zone_t;

endpackage

// file: design/hpt_top.sv
// module: harvester path threshold control register bank and decision top
//
// Summary of operation
// - path field acts only without charger input and with harvesting enabled.
// - harvesting disabled and no charger input: switch fully on, direct path.
// - charger input present: charger owns switch, path field ignored.
// - code 00 forces direct path regardless of battery voltage.
// - code 01: direct below threshold, ideal diode above it.
// - after entering ideal diode, recharge offset hysteresis applies to threshold.
// - code 10 forces ideal diode; code 11 reserved.
// - recharge offset codes mean threshold minus 70, 120, 170, 220 mV.
// - threshold 4.05 V plus 50 mV steps to 4.60 V; 1100-1111 reserved.
// - thermal field picks zones where monitoring allows harvesting; 00 off.
`timescale 1ns/100ps
module hpt_top (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        charger_input_i,
  input  wire logic        harvest_interaction_enable_i,
  input  wire logic [12:0] battery_mv_i,
  input  wire logic [1:0]  temp_zone_i,
  output logic             battery_system_switch_on_o,
  output logic             battery_system_diode_o,
  output logic             charger_owns_switch_o,
  output logic      [12:0] harvest_threshold_mv_o,
  output logic      [12:0] harvest_recharge_mv_o,
  output logic             harvest_charge_allow_o
);

  typedef struct packed {
    logic [7:0] path_cfg;
    logic [7:0] therm_cfg;
    logic [7:0] rdata;
    logic       allow;
  } hpt_top_state_t;

  hpt_top_state_t st;
  hpt_top_state_t next_st;
  hpt_cfg_if      cfg_bus ();
  logic [3:0]     thr_code;
  logic [1:0]     rechg_code;
  logic [1:0]     therm_sel;
  logic           zone_ok;
  logic           diode_mode;

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  assign thr_code   = st.path_cfg[hpt_pkg::REG_THR_MSB:hpt_pkg::REG_THR_LSB];
  assign rechg_code = st.path_cfg[hpt_pkg::RECHG_MSB:hpt_pkg::RECHG_LSB];
  assign therm_sel  = st.therm_cfg[hpt_pkg::THERM_SEL_MSB:hpt_pkg::THERM_SEL_LSB];

  assign cfg_bus.path_sel  = st.path_cfg[hpt_pkg::PATH_SEL_MSB:hpt_pkg::PATH_SEL_LSB];
  assign cfg_bus.thr_mv    = 13'(hpt_pkg::REG_THR_BASE_MV + 13'(thr_code) * hpt_pkg::REG_THR_STEP_MV);
  // reserved threshold codes disable automatic diode entry rather than guess a level
  assign cfg_bus.thr_valid = (thr_code <= hpt_pkg::REG_THR_MAX);
  assign cfg_bus.rechg_mv  = 13'(hpt_pkg::RECHG_BASE_MV + 13'(rechg_code) * hpt_pkg::RECHG_STEP_MV);

  always_comb begin
    case (therm_sel)
      2'b00:   zone_ok = 1'b1;
      2'b01:   zone_ok = (temp_zone_i == hpt_pkg::HPT_ZONE_COOL) || (temp_zone_i == hpt_pkg::HPT_ZONE_ROOM);
      2'b10:   zone_ok = (temp_zone_i == hpt_pkg::HPT_ZONE_ROOM) || (temp_zone_i == hpt_pkg::HPT_ZONE_WARM);
      2'b11:   zone_ok = (temp_zone_i != hpt_pkg::HPT_ZONE_OUT);
      default: zone_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank
  always_comb begin
    next_st = st;
    if (reg_wr_i && reg_addr_i == hpt_pkg::PATH_CONFIG_ADDR) begin
      next_st.path_cfg = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == hpt_pkg::THERMAL_CFG_ADDR) begin
      next_st.therm_cfg = reg_wdata_i;
    end
    // unmapped addresses read as zero
    case (reg_addr_i)
      hpt_pkg::PATH_CONFIG_ADDR: next_st.rdata = st.path_cfg;
      hpt_pkg::THERMAL_CFG_ADDR: next_st.rdata = st.therm_cfg;
      default:                   next_st.rdata = 8'h00;
    endcase
    // monitoring only gates harvesting while harvesting is enabled and charger is absent
    next_st.allow = harvest_interaction_enable_i && !charger_input_i && zone_ok;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st.path_cfg  <= hpt_pkg::PATH_CONFIG_RESET;
      st.therm_cfg <= hpt_pkg::THERMAL_CFG_RESET;
      st.rdata     <= 8'h00;
      st.allow     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // path decision
  hpt_path_decider u_dec (
    .ref_clk_i                    (ref_clk_i),
    .nrst_i                       (nrst_i),
    .cfg                          (cfg_bus),
    .charger_input_i              (charger_input_i),
    .harvest_interaction_enable_i (harvest_interaction_enable_i),
    .battery_mv_i                 (battery_mv_i),
    .diode_mode_o                 (diode_mode),
    .charger_owns_o               (charger_owns_switch_o)
  );

  assign reg_rdata_o                = st.rdata;
  assign battery_system_diode_o     = diode_mode;
  assign battery_system_switch_on_o = !diode_mode && !charger_owns_switch_o;
  assign harvest_threshold_mv_o     = cfg_bus.thr_mv;
  assign harvest_recharge_mv_o      = 13'(cfg_bus.thr_mv - cfg_bus.rechg_mv);
  assign harvest_charge_allow_o     = st.allow;

endmodule

// file: testbench/hpt_assertions.sv
// checker: port relations of the harvester path control top
`timescale 1ns/100ps
module hpt_assertions (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        charger_input_i,
  input wire logic        harvest_interaction_enable_i,
  input wire logic        battery_system_switch_on_o,
  input wire logic        battery_system_diode_o,
  input wire logic        charger_owns_switch_o,
  input wire logic [12:0] harvest_threshold_mv_o,
  input wire logic [12:0] harvest_recharge_mv_o,
  input wire logic        harvest_charge_allow_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_charger_takes_over: assert property (charger_input_i |=> charger_owns_switch_o)
    else $error("charger did not take the switch");
  a_charger_hands_back: assert property (!charger_input_i |=> !charger_owns_switch_o)
    else $error("charger kept the switch");
  a_disabled_direct_path: assert property (!charger_input_i && !harvest_interaction_enable_i
    |=> battery_system_switch_on_o && !battery_system_diode_o) else $error("direct path lost");
  a_diode_needs_enable: assert property ($rose(battery_system_diode_o)
    |-> $past(!charger_input_i && harvest_interaction_enable_i)) else $error("diode without enable");
  a_offset_decode: assert property (harvest_threshold_mv_o - harvest_recharge_mv_o
    inside {13'h0046, 13'h0078, 13'h00AA, 13'h00DC}) else $error("bad recharge offset");
  a_threshold_step: assert property ((harvest_threshold_mv_o - hpt_pkg::REG_THR_BASE_MV) % 50 == 0)
    else $error("threshold off the step grid");
  a_allow_gated_off: assert property (charger_input_i || !harvest_interaction_enable_i
    |=> !harvest_charge_allow_o) else $error("harvest allowed while gated");
  a_config_readback: assert property (reg_wr_i && reg_addr_i == hpt_pkg::PATH_CONFIG_ADDR ##1
    reg_addr_i == hpt_pkg::PATH_CONFIG_ADDR |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("config readback wrong");
  c_diode_on: cover property ($rose(battery_system_diode_o));
  c_diode_off: cover property ($fell(battery_system_diode_o));
  c_charger: cover property ($rose(charger_owns_switch_o));
endmodule
bind hpt_top hpt_assertions chk (.ref_clk_i, .nrst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
  .charger_input_i, .harvest_interaction_enable_i, .battery_system_switch_on_o, .battery_system_diode_o,
  .charger_owns_switch_o, .harvest_threshold_mv_o, .harvest_recharge_mv_o, .harvest_charge_allow_o);

// file: testbench/tb.sv
// testbench: register accesses and path decisions
`timescale 1ns/100ps
`define CHK(n,e,s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
  logic        ref_clk_i, nrst_i, wr, chg, en, sw, di, ow, al;
  logic [7:0]  addr, wd, rd;
  logic [12:0] bat, thr, rch, e;
  logic [1:0]  zone;
  int          err_total, n_checks;
  hpt_top uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd),
    .reg_rdata_o(rd), .charger_input_i(chg), .harvest_interaction_enable_i(en), .battery_mv_i(bat),
    .temp_zone_i(zone), .battery_system_switch_on_o(sw), .battery_system_diode_o(di),
    .charger_owns_switch_o(ow), .harvest_threshold_mv_o(thr), .harvest_recharge_mv_o(rch),
    .harvest_charge_allow_o(al));
  initial begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    step(1);
    addr = a;
    wd   = d;
    wr   = 1;
    step(1);
    wr = 0;
  endtask
  // one battery level, two edges to settle, then both path outputs
  task bat_step(input logic [12:0] b, input logic d);
    bat = b;
    step(2);
    `CHK("auto diode", d, di)
    `CHK("auto switch", !d, sw)
  endtask
  task path(input logic [1:0] c, input logic [12:0] b, input logic s, input logic d);
    wreg(8'h18, {c, 6'h30});
    bat = b;
    step(2);
    `CHK("switch", s, sw)
    `CHK("diode", d, di)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    final_report;
  end
  initial begin
    nrst_i    = 0;
    wr        = 0;
    chg       = 0;
    en        = 0;
    addr      = 8'h18;
    wd        = 0;
    bat       = 0;
    zone      = 0;
    err_total = 0;
    n_checks  = 0;
    step(10);
    nrst_i = 1;
    step(1);
    `CHK("rst rdata", 8'h00, rd)
    `CHK("rst switch", 1'b1, sw)
    for (int i = 0; i < 12; i++) begin
      wreg(8'h18, {2'b01, i[1:0], i[3:0]});
      step(1);
      e = 13'h0FD2 + 13'(50 * i);
      `CHK("thr", e, thr)
      `CHK("rechg", e - 13'(70 + 50 * i[1:0]), rch)
      `CHK("rdata", {2'b01, i[1:0], i[3:0]}, rd)
    end
    wreg(8'h20, 8'hFF);
    step(1);
    `CHK("unmapped", 8'h00, rd)
    // the ignored write must leave the last configuration in place
    addr = 8'h18;
    step(1);
    `CHK("kept", 8'h7B, rd)
    en = 1;
    wreg(8'h18, 8'h70);
    bat_step(13'd3831, 1'b0);
    bat_step(13'd4050, 1'b0);
    bat_step(13'd4051, 1'b1);
    bat_step(13'd4050, 1'b1);
    bat_step(13'd3830, 1'b1);
    bat_step(13'd3829, 1'b0);
    // reserved threshold code keeps the direct path even far above any level
    wreg(8'h18, 8'h4C);
    bat_step(13'd4900, 1'b0);
    path(2'b00, 13'd4500, 1'b1, 1'b0);
    path(2'b10, 13'd3000, 1'b0, 1'b1);
    path(2'b11, 13'd4500, 1'b1, 1'b0);
    path(2'b10, 13'd3000, 1'b0, 1'b1);
    chg = 1;
    step(2);
    `CHK("owns", 1'b1, ow)
    `CHK("chg diode", 1'b0, di)
    `CHK("chg sw", 1'b0, sw)
    chg = 0;
    step(2);
    `CHK("owns off", 1'b0, ow)
    `CHK("back diode", 1'b1, di)
    en = 0;
    step(2);
    `CHK("off sw", 1'b1, sw)
    `CHK("off diode", 1'b0, di)
    en = 1;
    for (int t = 0; t < 4; t++) begin
      wreg(8'h17, {t[1:0], 6'h00});
      for (int z = 0; z < 4; z++) begin
        zone = z[1:0];
        step(2);
        `CHK("allow", (t == 0) || (z != 3 && (t == 3 || (t == 1 && z < 2) || (t == 2 && z > 0))), al)
      end
      `CHK("therm rd", {t[1:0], 6'h00}, rd)
    end
    chg = 1;
    step(2);
    `CHK("allow chg", 1'b0, al)
    // mid-run reset clears the stored fields and the registered permission
    nrst_i = 0;
    step(1);
    `CHK("rst2 rdata", 8'h00, rd)
    `CHK("rst2 allow", 1'b0, al)
    nrst_i = 1;
    step(1);
    `CHK("rst2 therm", 8'h00, rd)
    final_report;
  end
endmodule
